//--- common/acdp_pkg.sv
package acdp_pkg;
    localparam logic [7:0] IDX_MASK = 8'h40;
    localparam logic [7:0] IDX_LOWER = 8'h41;
    localparam logic [7:0] IDX_UPPER = 8'h42;
    localparam logic [7:0] IDX_AVG = 8'h43;
    localparam logic [7:0] IDX_FUNC = 8'h44;
    localparam logic [7:0] IDX_PEND = 8'h45;
    localparam logic [7:0] IDX_TEMP = 8'h97;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] MODE_IN_U_UNI = 8'h01;
    localparam logic [7:0] MODE_IN_U_BI = 8'h02;
    localparam logic [7:0] MODE_IN_I_020 = 8'h03;
    localparam logic [7:0] MODE_IN_I_420 = 8'h04;
    localparam logic [7:0] MODE_OUT_U_UNI = 8'h06;
    localparam logic [7:0] MODE_OUT_U_BI = 8'h07;
    localparam logic [7:0] MODE_OUT_I_020 = 8'h08;
    localparam logic [7:0] MODE_OUT_I_420 = 8'h09;
    ////////////////////////////////////////////////////////////////////////
    localparam int BIT_LOW = 1;
    localparam int BIT_HIGH = 2;
    localparam int BIT_OTEMP = 3;
    localparam int BIT_OVOLT = 4;
    localparam int BIT_UVOLT = 5;
    localparam int BIT_CH_LO = 6;
    localparam int BIT_CH_HI = 7;
    localparam int BIT_DEFECT = 8;
    localparam int BIT_CABLE = 10;
    localparam int BIT_OCUR = 11;
    localparam int BIT_UNDER = 14;
    localparam int BIT_OVER = 15;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] RST_LOWER = 16'h8000;
    localparam logic [15:0] RST_UPPER = 16'h7fff;
    localparam logic [7:0] RST_AVG = 8'h00;
    localparam logic [15:0] RST_MASK_OUT_I = 16'hcc3e;
    localparam logic [15:0] RST_MASK_OUT_U = 16'hc8fe;
    localparam logic [15:0] RST_MASK_IN = 16'hc83e;
    localparam logic [7:0] AVG_MAX = 8'h40;
    localparam logic signed [15:0] FULL_SCALE = 16'sh6c00;
    localparam logic signed [7:0] TEMP_MAX_C = 8'sh55;
    localparam logic [15:0] SUPPLY_MAX_DV = 16'h012c;
    localparam logic [15:0] SUPPLY_MIN_DV = 16'h00b4;
endpackage : acdp_pkg

//--- rtl/acdp_bank.sv
`timescale 1ns/1ps
module acdp_bank
    import acdp_pkg::*;
#(
    parameter bit OUTPUT_VARIANT = 1'b0,
    parameter bit MULTI = 1'b1,
    parameter logic [7:0] FIXED_MODE = MODE_IN_U_UNI
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] index,
    input wire logic [31:0] wdata,
    input wire logic signed [15:0] meas,
    input wire logic signed [7:0] temp_c,
    input wire logic [15:0] supply_dv,
    input wire logic sensor_oc,
    input wire logic dev_fault,
    input wire logic cable_break,
    input wire logic chan_err_lo,
    input wire logic chan_err_hi,
    output logic ack,
    output logic err,
    output logic [31:0] rdata,
    output logic [15:0] event_pulse,
    output logic [31:0] pending,
    output logic [7:0] active_mode
);
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] lower;
        logic [15:0] upper;
        logic [7:0] avg;
        logic [7:0] mode;
        logic [31:0] pend;
        logic [7:0] temp;
        logic [15:0] evt;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } acdp_state_t;

    function automatic logic [15:0] reset_mask(input logic [7:0] m);
        if (!OUTPUT_VARIANT) begin
            reset_mask = RST_MASK_IN;
        end else if (m == MODE_OUT_I_020 || m == MODE_OUT_I_420) begin
            reset_mask = RST_MASK_OUT_I;
        end else begin
            reset_mask = RST_MASK_OUT_U;
        end
    endfunction : reset_mask

    function automatic logic mode_ok(input logic [7:0] m);
        if (OUTPUT_VARIANT) begin
            mode_ok = (m >= MODE_OUT_U_UNI) && (m <= MODE_OUT_I_420);
        end else begin
            mode_ok = (m >= MODE_IN_U_UNI) && (m <= MODE_IN_I_420);
        end
    endfunction : mode_ok

    acdp_state_t st;
    acdp_state_t next_st;
    logic [15:0] active;

    acdp_cond u_cond (
        .mode(st.mode),
        .meas(meas),
        .lower(st.lower),
        .upper(st.upper),
        .temp_c(temp_c),
        .supply_dv(supply_dv),
        .sensor_oc(sensor_oc),
        .dev_fault(dev_fault),
        .cable_break(cable_break),
        .chan_err_lo(chan_err_lo),
        .chan_err_hi(chan_err_hi),
        .active(active)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.err = 1'b0;
        next_st.rdata = '0;
        next_st.temp = temp_c;
        next_st.pend = {16'h0000, active};
        // new condition raises its event only if enabled
        next_st.evt = active & ~st.pend[15:0] & st.mask;
        if (req) begin
            case (index)
                IDX_MASK: begin
                    next_st.rdata = {16'h0000, st.mask};
                    if (wr) begin
                        next_st.mask = wdata[15:0];
                    end
                end
                IDX_LOWER: begin
                    next_st.rdata = {16'h0000, st.lower};
                    if (wr) begin
                        next_st.lower = wdata[15:0];
                    end
                end
                IDX_UPPER: begin
                    next_st.rdata = {16'h0000, st.upper};
                    if (wr) begin
                        next_st.upper = wdata[15:0];
                    end
                end
                IDX_AVG: begin
                    next_st.rdata = {24'h000000, st.avg};
                    if (wr && wdata[7:0] > AVG_MAX) begin
                        next_st.err = 1'b1;
                    end else if (wr) begin
                        next_st.avg = wdata[7:0];
                    end
                end
                IDX_FUNC: begin
                    next_st.rdata = {24'h000000, st.mode};
                    // fixed variant ignores the write silently
                    // only codes of this variant adopted
                    if (wr && MULTI && mode_ok(wdata[7:0])) begin
                        next_st.mode = wdata[7:0];
                    end else if (wr && MULTI) begin
                        next_st.err = 1'b1;
                    end
                end
                IDX_PEND: begin
                    next_st.rdata = st.pend;
                    next_st.err = wr;
                end
                IDX_TEMP: begin
                    next_st.rdata = {24'h000000, st.temp};
                    next_st.err = wr;
                end
                default: begin
                    next_st.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.mask <= reset_mask(FIXED_MODE);
            st.lower <= RST_LOWER;
            st.upper <= RST_UPPER;
            st.avg <= RST_AVG;
            st.mode <= FIXED_MODE;
        end else begin
            st <= next_st;
        end
    end

    assign ack = st.ack;
    assign err = st.err;
    assign rdata = st.rdata;
    assign event_pulse = st.evt;
    assign pending = st.pend;
    assign active_mode = st.mode;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence avg_bad_write;
        req && wr && index == IDX_AVG && wdata[7:0] > AVG_MAX;
    endsequence

    sequence avg_refused;
        err && $stable(st.avg);
    endsequence

    ack_timing_a: assert property (req |=> ack)
        else $error("answer missing one cycle after request");
    avg_range_a: assert property (avg_bad_write |=> avg_refused)
        else $error("bad averaging length was not refused");
    avg_store_a: assert property (req && wr && index == IDX_AVG
        && wdata[7:0] <= AVG_MAX |=> !err && st.avg == $past(wdata[7:0]))
        else $error("valid averaging length not stored");
    event_gate_a: assert property (
        (event_pulse & ~$past(st.mask)) == '0)
        else $error("event raised for a disabled bit");
    pend_reserved_a: assert property (pending[31:16] == 16'h0000)
        else $error("reserved pending bits set");
    otemp_pend_a: assert property ($past(temp_c) > TEMP_MAX_C
        |-> pending[BIT_OTEMP])
        else $error("overtemperature not pending");
    fixed_mode_a: assert property (
        !MULTI |-> active_mode == FIXED_MODE)
        else $error("fixed variant changed its mode");
    ocur_evt_a: assert property (sensor_oc && !pending[BIT_OCUR]
        && st.mask[BIT_OCUR] |=> event_pulse[BIT_OCUR])
        else $error("overcurrent event missing");
    mode_legal_a: assert property (mode_ok(active_mode))
        else $error("selector holds a code foreign to the variant");
    defect_bit_a: assert property (active_mode != MODE_IN_I_020
        |=> !pending[BIT_DEFECT])
        else $error("defect pending outside 0-20 mA input");
endmodule : acdp_bank

//--- rtl/acdp_cond.sv
`timescale 1ns/1ps
module acdp_cond
    import acdp_pkg::*;
(
    input wire logic [7:0] mode,
    input wire logic signed [15:0] meas,
    input wire logic signed [15:0] lower,
    input wire logic signed [15:0] upper,
    input wire logic signed [7:0] temp_c,
    input wire logic [15:0] supply_dv,
    input wire logic sensor_oc,
    input wire logic dev_fault,
    input wire logic cable_break,
    input wire logic chan_err_lo,
    input wire logic chan_err_hi,
    output logic [15:0] active
);
    logic [15:0] raw;
    logic [15:0] defined;
    logic bipolar;
    logic out_cur;
    logic out_volt;

    always_comb begin
        bipolar = (mode == MODE_IN_U_BI) || (mode == MODE_OUT_U_BI);
        out_cur = (mode == MODE_OUT_I_020) || (mode == MODE_OUT_I_420);
        out_volt = (mode == MODE_OUT_U_UNI) || (mode == MODE_OUT_U_BI);
        raw = '0;
        raw[BIT_LOW] = meas < lower;
        raw[BIT_HIGH] = meas > upper;
        raw[BIT_OTEMP] = temp_c > TEMP_MAX_C;
        raw[BIT_OVOLT] = supply_dv > SUPPLY_MAX_DV;
        raw[BIT_UVOLT] = supply_dv < SUPPLY_MIN_DV;
        raw[BIT_CH_LO] = chan_err_lo;
        raw[BIT_CH_HI] = chan_err_hi;
        raw[BIT_DEFECT] = dev_fault;
        raw[BIT_CABLE] = cable_break;
        raw[BIT_OCUR] = sensor_oc;
        // range ends; 4 mA and 0 V map to code zero
        raw[BIT_UNDER] = bipolar ? (meas < -FULL_SCALE) : (meas < 16'sh0000);
        raw[BIT_OVER] = meas > FULL_SCALE;
        defined = '0;
        defined[BIT_LOW] = 1'b1;
        defined[BIT_HIGH] = 1'b1;
        defined[BIT_OTEMP] = 1'b1;
        defined[BIT_OVOLT] = 1'b1;
        defined[BIT_UVOLT] = 1'b1;
        defined[BIT_OCUR] = 1'b1;
        defined[BIT_UNDER] = 1'b1;
        defined[BIT_OVER] = 1'b1;
        // defect only in 0-20 mA input
        defined[BIT_DEFECT] = mode == MODE_IN_I_020;
        defined[BIT_CH_LO] = out_volt;
        defined[BIT_CH_HI] = out_volt;
        defined[BIT_CABLE] = out_cur;
        active = raw & defined;
    end
endmodule : acdp_cond

//--- sim/acdp_bank_test.sv
`timescale 1ns/1ps
module acdp_bank_test;
    import acdp_pkg::*;
    typedef struct packed {
        logic [7:0] mode;
        logic [15:0] meas;
        logic [7:0] temp;
        logic [15:0] sup;
        logic [4:0] flg;
        logic [15:0] expv;
    } acdp_case_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req, wr, ack, err, sensor_oc, dev_fault, cable_break;
    logic chan_err_lo, chan_err_hi;
    logic ev_clr, ack2, err2;
    logic [7:0] active_mode2;
    logic [31:0] pending2;
    logic [7:0] index, active_mode;
    logic signed [7:0] temp_c;
    logic signed [15:0] meas;
    logic [15:0] supply_dv, event_pulse, ev_seen, mask_now;
    logic [31:0] wdata, rdata, pending;
    int n_errors = 0;
    int num_checks = 0;
    // Flags: sensor_oc, dev_fault, cable_break, chan_err_lo, chan_err_hi
    acdp_case_t tbl[17] = '{
        '{8'h01, 16'h03e8, 8'h56, 16'h00f0, 5'h00, 16'h0008},
        '{8'h01, 16'h03e8, 8'h55, 16'h00f0, 5'h00, 16'h0000},
        '{8'h01, 16'h03e8, 8'h19, 16'h012d, 5'h00, 16'h0010},
        '{8'h01, 16'h03e8, 8'h19, 16'h012c, 5'h00, 16'h0000},
        '{8'h01, 16'h03e8, 8'h19, 16'h00b3, 5'h00, 16'h0020},
        '{8'h01, 16'h03e8, 8'h19, 16'h00b4, 5'h00, 16'h0000},
        '{8'h01, 16'h03e8, 8'h19, 16'h00f0, 5'h10, 16'h0800},
        '{8'h01, 16'h03e8, 8'h19, 16'h00f0, 5'h0f, 16'h0000},
        '{8'h01, 16'hffff, 8'h19, 16'h00f0, 5'h00, 16'h4000},
        '{8'h01, 16'h6c01, 8'h19, 16'h00f0, 5'h00, 16'h8000},
        '{8'h02, 16'hffff, 8'h19, 16'h00f0, 5'h00, 16'h0000},
        '{8'h02, 16'h93ff, 8'h19, 16'h00f0, 5'h00, 16'h4000},
        '{8'h03, 16'h03e8, 8'h19, 16'h00f0, 5'h08, 16'h0100},
        '{8'h03, 16'h6c01, 8'h19, 16'h00f0, 5'h00, 16'h8000},
        '{8'h03, 16'hffff, 8'h19, 16'h00f0, 5'h00, 16'h4000},
        '{8'h04, 16'h03e8, 8'h19, 16'h00f0, 5'h08, 16'h0000},
        '{8'h04, 16'hffff, 8'h19, 16'h00f0, 5'h00, 16'h4000}
    };
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        ev_seen <= ev_clr ? 16'h0000 : (ev_seen | event_pulse);
    end
    acdp_master m (.mclk(mclk), .req(req), .wr(wr), .index(index),
        .wdata(wdata), .ack(ack), .err(err), .rdata(rdata));
    acdp_bank DUT (.mclk(mclk), .rst(rst), .req(req), .wr(wr),
        .index(index), .wdata(wdata), .meas(meas), .temp_c(temp_c),
        .supply_dv(supply_dv), .sensor_oc(sensor_oc),
        .dev_fault(dev_fault), .cable_break(cable_break),
        .chan_err_lo(chan_err_lo), .chan_err_hi(chan_err_hi), .ack(ack),
        .err(err), .rdata(rdata), .event_pulse(event_pulse),
        .pending(pending), .active_mode(active_mode));
    // Fixed output-current variant on the same bus must ignore selector writes
    acdp_bank #(.OUTPUT_VARIANT(1'b1), .MULTI(1'b0),
        .FIXED_MODE(MODE_OUT_I_420)) DUT2 (.mclk(mclk), .rst(rst), .req(req),
        .wr(wr), .index(index), .wdata(wdata), .meas(meas), .temp_c(temp_c),
        .supply_dv(supply_dv), .sensor_oc(sensor_oc),
        .dev_fault(dev_fault), .cable_break(cable_break),
        .chan_err_lo(chan_err_lo), .chan_err_hi(chan_err_hi), .ack(ack2),
        .err(err2), .rdata(), .event_pulse(),
        .pending(pending2), .active_mode(active_mode2));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] expv);
        num_checks++;
        if (got !== expv) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, expv);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] idx,
            input logic [31:0] d, input logic [31:0] expv, input logic ee);
        logic [31:0] q;
        logic e;
        logic a;
        m.xfer(w, idx, d, q, e, a);
        check({30'h0, a, e}, {30'h0, 1'b1, ee});
        if (!w && !ee)
            check(q, expv);
    endtask : acc
    // Quiet inputs first, so every event seen belongs to this case
    task automatic run_case(input acdp_case_t c);
        acc(1'b1, IDX_FUNC, {24'h0, c.mode}, 32'h0, 1'b0);
        @(posedge mclk);
        meas <= 16'sh03e8;
        temp_c <= 8'sh19;
        supply_dv <= 16'h00f0;
        {sensor_oc, dev_fault, cable_break, chan_err_lo, chan_err_hi} <= 5'h0;
        repeat (3) @(posedge mclk);
        ev_clr <= 1'b1;
        @(posedge mclk);
        ev_clr <= 1'b0;
        meas <= c.meas;
        temp_c <= c.temp;
        supply_dv <= c.sup;
        {sensor_oc, dev_fault, cable_break, chan_err_lo, chan_err_hi} <= c.flg;
        repeat (3) @(posedge mclk);
        #1;
        check({16'h0, ev_seen}, {16'h0, c.expv & mask_now});
        check(pending, {16'h0, c.expv});
        check({24'h0, active_mode}, {24'h0, c.mode});
        acc(1'b0, IDX_PEND, 32'h0, {16'h0, c.expv}, 1'b0);
    endtask : run_case
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    // Run needs about 370 cycles; about eighty times that is a hang
    initial begin
        #1200000;
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        meas = 16'sh03e8;
        temp_c = 8'sh19;
        supply_dv = 16'h00f0;
        {sensor_oc, dev_fault, cable_break, chan_err_lo, chan_err_hi} = 5'h0;
        ev_clr = 1'b1;
        mask_now = RST_MASK_IN;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        acc(1'b0, IDX_MASK, 32'h0, {16'h0, RST_MASK_IN}, 1'b0);
        acc(1'b0, IDX_LOWER, 32'h0, 32'h8000, 1'b0);
        acc(1'b0, IDX_UPPER, 32'h0, 32'h7fff, 1'b0);
        acc(1'b0, IDX_AVG, 32'h0, 32'h0, 1'b0);
        acc(1'b0, IDX_FUNC, 32'h0, 32'h01, 1'b0);
        acc(1'b0, IDX_PEND, 32'h0, 32'h0, 1'b0);
        acc(1'b0, IDX_TEMP, 32'h0, 32'h19, 1'b0);
        acc(1'b0, 8'h50, 32'h0, 32'h0, 1'b1);
        acc(1'b1, IDX_PEND, 32'h0, 32'h0, 1'b1);
        acc(1'b1, IDX_TEMP, 32'h0, 32'h0, 1'b1);
        acc(1'b1, IDX_AVG, 32'h41, 32'h0, 1'b1);
        acc(1'b0, IDX_AVG, 32'h0, 32'h0, 1'b0);
        acc(1'b1, IDX_AVG, 32'h40, 32'h0, 1'b0);
        acc(1'b0, IDX_AVG, 32'h0, 32'h40, 1'b0);
        acc(1'b1, IDX_FUNC, 32'h06, 32'h0, 1'b1);
        check({30'h0, ack2, err2}, 32'h2);
        acc(1'b0, IDX_FUNC, 32'h0, 32'h01, 1'b0);
        foreach (tbl[i])
            run_case(tbl[i]);
        acc(1'b1, IDX_MASK, 32'h0, 32'h0, 1'b0);
        mask_now = 16'h0000;
        run_case('{8'h01, 16'h03e8, 8'h56, 16'h00f0, 5'h10, 16'h0808});
        acc(1'b1, IDX_MASK, 32'hffff, 32'h0, 1'b0);
        mask_now = 16'hffff;
        run_case('{8'h01, 16'h03e8, 8'h19, 16'h00f0, 5'h0f, 16'h0000});
        check(pending2, 32'h0400);
        check({24'h0, active_mode2}, {24'h0, MODE_OUT_I_420});
        acc(1'b1, IDX_LOWER, 32'h64, 32'h0, 1'b0);
        run_case('{8'h01, 16'h0032, 8'h19, 16'h00f0, 5'h00, 16'h0002});
        // Upper limit stays above the quiet level so the case sees an edge
        acc(1'b1, IDX_UPPER, 32'h7d0, 32'h0, 1'b0);
        run_case('{8'h01, 16'h0834, 8'h19, 16'h00f0, 5'h00, 16'h0004});
        wrap_up();
    end
endmodule : acdp_bank_test

//--- sim/acdp_master.sv
`timescale 1ns/1ps
module acdp_master (
    input wire logic mclk,
    output logic req,
    output logic wr,
    output logic [7:0] index,
    output logic [31:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    initial begin
        req = 1'b0;
        wr = 1'b0;
        index = 8'h00;
        wdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One-cycle request; answer stands only in the next cycle
    task automatic xfer(input logic w, input logic [7:0] idx,
            input logic [31:0] d, output logic [31:0] q, output logic e,
            output logic a);
        @(posedge mclk);
        req <= 1'b1;
        wr <= w;
        index <= idx;
        wdata <= d;
        @(posedge mclk);
        req <= 1'b0;
        // Released lines flip so stale values never look valid
        wr <= ~w;
        index <= ~idx;
        wdata <= ~d;
        // Answer taken at the edge where ack is sampled high
        @(posedge mclk);
        q = rdata;
        e = err;
        a = ack;
    endtask : xfer
endmodule : acdp_master
